//--- include/dco_pkg.sv
// shared constants and types for the dithered clock output controller
package dco_pkg;
   // apb register byte offsets
   localparam logic [7:0] ADDR_DIVIDE   = 8'h00;
   localparam logic [7:0] ADDR_DITHER   = 8'h04;
   localparam logic [7:0] ADDR_TUNE     = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0c;
   localparam logic [7:0] ADDR_NVWRITE  = 8'h10;
   // field layout of the divide register
   localparam int DIV_EXP_LSB  = 0;
   localparam int DIV_IDLE_BIT = 4;
   // field layout of the dither register
   localparam int DITH_DEPTH_LSB = 0;
   localparam int DITH_RATE_LSB  = 4;
   // field layout of the tuning register
   localparam int TUNE_FINE_LSB   = 0;
   localparam int TUNE_COARSE_LSB = 16;
   // reset values
   localparam logic [3:0] RST_EXP    = 4'h0;
   localparam logic       RST_IDLE   = 1'b1;
   localparam logic [2:0] RST_DEPTH  = 3'h0;
   localparam logic [1:0] RST_RATE   = 2'h1;
   localparam logic [9:0] RST_FINE   = 10'h1f4;
   localparam logic [4:0] RST_COARSE = 5'h10;
   // timing
   localparam int MAX_EXP           = 8;
   localparam int STARTUP_CYCLES    = 512;
   localparam int MCLK_HZ           = 25_000_000;
   localparam int NV_WRITE_MS       = 10;
   localparam int NV_WRITE_CYCLES   = NV_WRITE_MS * (MCLK_HZ / 1000);
   localparam int PDN_DEGLITCH_US   = 10;
   localparam int PDN_DEGLITCH_CYC  = (PDN_DEGLITCH_US * MCLK_HZ + 999_999) / 1_000_000;
   localparam int FINE_STEP_KHZ     = 5;
   localparam int DAC_SPAN          = 1024;

   typedef enum logic [1:0] {
      DCO_OFF    = 2'b00,
      DCO_SETTLE = 2'b01,
      DCO_RUN    = 2'b10
   } dco_state_type;

   typedef struct packed {
      logic [3:0] divExp;
      logic       idleLow;
      logic [2:0] ditherDepth;
      logic [1:0] ditherRate;
      logic [9:0] fineTune;
      logic [4:0] coarseRange;
   } dco_cfg_type;
endpackage : dco_pkg

//--- src/dco_top.sv
// dithered clock output controller: apb registers, master counter, dither and divider
//
// Functional notes
// - dither only while ditherEnable pin is high.
// - outputGate high drives output; low disables output, oscillator keeps running.
// - powerUp low stops oscillator, enters power-down, output off.
// - output is master divided by two to the exponent, zero to eight.
// - output stays off after reset until 512 master cycles elapsed.
// - gate and power-down changes take effect only at divided clock low phase.
// - dither only lowers frequency below the programmed value.
// - triangle dither with depth 0.5, 1, 2, 4 or 8 percent; the code makes a triangle only at rate code 00, other rates jump between ramps.
// - dither rate bits set triangle modulation frequency.
// - master spans the two-to-one band; each fine step is 5 kHz.
// - coarse range selects sub-band swept by fine tuning word.
// - nonvolatile write busy at most 10 ms; host waits for it.
// - serial bits captured on rising, changed after falling clock edge.
// - data line is only pulled low or released.
// - after power-down exit output starts after settle, frequency settles later.
// - frequency moves gradually toward new settings.
// - startup settle lasts 512 master periods.
// - depth codes 000,001,010,100,111 give 0.5,1,2,4,8 percent; others reserved.
// - rate codes 00,01,10 give master over 8192,4096,2048.
// - idle output floats when idle bit is 0, driven low when 1.
// - exponent above eight acts as eight.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dco_top #(
   parameter int NV_CYCLES     = dco_pkg::NV_WRITE_CYCLES,
   parameter int PHASE_BITS    = 24,
   parameter int STARTUP_COUNT = dco_pkg::STARTUP_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ditherEnable,
   input  wire logic        outputGate,
   input  wire logic        powerUp,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   output logic             clkOut,
   output logic             clkOutOe,
   output logic             settled
);
   initial begin
      if (PHASE_BITS < 16 || STARTUP_COUNT < 1 || NV_CYCLES < 1)
         $error("dco_top: unsupported parameter values");
   end

   dco_pkg::dco_cfg_type   cfg_q, cfg_d;
   dco_pkg::dco_state_type state_q, state_d;
   logic [PHASE_BITS-1:0]  phase_q, phase_d;
   logic [15:0]            step_q, step_d;
   logic [8:0]             divCnt_q, divCnt_d;
   logic [9:0]             startCnt_q, startCnt_d;
   logic [23:0]            nvCnt_q, nvCnt_d;
   logic [13:0]            triCnt_q, triCnt_d;
   logic                   gateOn_q, gateOn_d;
   logic [31:0]            prdata_q, prdata_d;
   logic [9:0]             settleCnt_q, settleCnt_d;
   logic                   sclPrev_q, sdaBit_q;

   logic        apbWr, apbRd, addrOk;
   logic [15:0] targetStep, ditherDrop, effStep, triMag;
   logic        masterTick, tap;
   logic [3:0]  expSat;
   logic [13:0] halfPeriod;

   assign apbWr = psel && penable && pwrite;
   // read data is captured in the setup cycle so it already stands at the access edge
   assign apbRd = psel && !penable && !pwrite;
   assign addrOk = (paddr == dco_pkg::ADDR_DIVIDE) || (paddr == dco_pkg::ADDR_DITHER) ||
                   (paddr == dco_pkg::ADDR_TUNE) || (paddr == dco_pkg::ADDR_STATUS) ||
                   (paddr == dco_pkg::ADDR_NVWRITE);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addrOk;
   assign prdata  = prdata_q;

   // frequency word: base of the coarse band plus fine steps; scaled so that the
   // band edge maps to a phase step of a 25 MHz accumulator
   always_comb begin
      targetStep = 16'(({11'h0, cfg_q.coarseRange} << 9) + {6'h0, cfg_q.fineTune} + 16'h4000);
   end

   // one-sided dither, a triangle only at rate code 00: magnitude only ever subtracts from step_q
   always_comb begin
      case (cfg_q.ditherDepth)
         3'b000:  ditherDrop = triMag >> 9;
         3'b001:  ditherDrop = triMag >> 8;
         3'b010:  ditherDrop = triMag >> 7;
         3'b100:  ditherDrop = triMag >> 6;
         3'b111:  ditherDrop = triMag >> 5;
         default: ditherDrop = 16'h0;
      endcase
      effStep = (ditherEnable && state_q == dco_pkg::DCO_RUN) ? step_q - ditherDrop : step_q;
   end

   always_comb begin
      case (cfg_q.ditherRate)
         2'b00:   halfPeriod = 14'd4095;
         2'b10:   halfPeriod = 14'd1023;
         default: halfPeriod = 14'd2047;
      endcase
      triMag = triCnt_q[12] ? 16'({triCnt_q[11:0], 4'h0}) : 16'({~triCnt_q[11:0], 4'h0});
   end

   assign masterTick = phase_d[PHASE_BITS-1] && !phase_q[PHASE_BITS-1];
   assign expSat = (cfg_q.divExp > 4'(dco_pkg::MAX_EXP)) ? 4'(dco_pkg::MAX_EXP) : cfg_q.divExp;
   assign tap = (expSat == 4'h0) ? phase_q[PHASE_BITS-1] : divCnt_q[expSat-4'h1];
   always_comb begin
      cfg_d       = cfg_q;
      state_d     = state_q;
      phase_d     = phase_q;
      step_d      = step_q;
      divCnt_d    = divCnt_q;
      startCnt_d  = startCnt_q;
      nvCnt_d     = nvCnt_q;
      triCnt_d    = triCnt_q;
      gateOn_d    = gateOn_q;
      prdata_d    = prdata_q;
      settleCnt_d = settleCnt_q;
      if (apbWr) begin
         if (paddr == dco_pkg::ADDR_DIVIDE) begin
            cfg_d.divExp  = pwdata[dco_pkg::DIV_EXP_LSB +: 4];
            cfg_d.idleLow = pwdata[dco_pkg::DIV_IDLE_BIT];
         end else if (paddr == dco_pkg::ADDR_DITHER) begin
            cfg_d.ditherDepth = pwdata[dco_pkg::DITH_DEPTH_LSB +: 3];
            cfg_d.ditherRate  = pwdata[dco_pkg::DITH_RATE_LSB +: 2];
         end else if (paddr == dco_pkg::ADDR_TUNE) begin
            cfg_d.fineTune    = pwdata[dco_pkg::TUNE_FINE_LSB +: 10];
            cfg_d.coarseRange = pwdata[dco_pkg::TUNE_COARSE_LSB +: 5];
         end else if (paddr == dco_pkg::ADDR_NVWRITE) begin
            nvCnt_d = 24'(NV_CYCLES);
         end
      end
      if (nvCnt_q != 24'h0 && !(apbWr && paddr == dco_pkg::ADDR_NVWRITE))
         nvCnt_d = nvCnt_q - 24'h1;
      if (apbRd) begin
         if (paddr == dco_pkg::ADDR_DIVIDE)
            prdata_d = 32'({cfg_q.idleLow, cfg_q.divExp});
         else if (paddr == dco_pkg::ADDR_DITHER)
            prdata_d = 32'({cfg_q.ditherRate, 1'b0, cfg_q.ditherDepth});
         else if (paddr == dco_pkg::ADDR_TUNE)
            prdata_d = 32'({cfg_q.coarseRange, 6'h0, cfg_q.fineTune});
         else if (paddr == dco_pkg::ADDR_STATUS)
            prdata_d = 32'({nvCnt_q != 24'h0, settled, gateOn_q, state_q});
         else
            prdata_d = 32'h0;
      end
      // slew one step per master tick toward the target
      if (masterTick) begin
         if (step_q < targetStep)
            step_d = step_q + 16'h1;
         else if (step_q > targetStep)
            step_d = step_q - 16'h1;
         settleCnt_d = (step_q == targetStep) ? 10'h0 : 10'h3ff;
      end
      case (state_q)
         dco_pkg::DCO_OFF: begin
            phase_d    = '0;
            startCnt_d = 10'h0;
            gateOn_d   = 1'b0;
            if (powerUp)
               state_d = dco_pkg::DCO_SETTLE;
         end
         dco_pkg::DCO_SETTLE: begin
            phase_d = phase_q + PHASE_BITS'(effStep);
            if (masterTick) begin
               divCnt_d   = divCnt_q + 9'h1;
               startCnt_d = startCnt_q + 10'h1;
            end
            if (!powerUp)
               state_d = dco_pkg::DCO_OFF;
            else if (startCnt_q == 10'(STARTUP_COUNT))
               state_d = dco_pkg::DCO_RUN;
         end
         dco_pkg::DCO_RUN: begin
            phase_d = phase_q + PHASE_BITS'(effStep);
            if (masterTick) begin
               divCnt_d = divCnt_q + 9'h1;
               triCnt_d = (triCnt_q[11:0] >= 12'(halfPeriod)) ? 14'({~triCnt_q[12], 12'h0})
                                                             : triCnt_q + 14'h1;
            end
            // gate changes only while divided clock is low, so no short pulse
            if (!tap)
               gateOn_d = outputGate && powerUp;
            if (!powerUp && !tap && !gateOn_q)
               state_d = dco_pkg::DCO_OFF;
         end
         default: state_d = dco_pkg::DCO_OFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg_q       <= '{dco_pkg::RST_EXP, dco_pkg::RST_IDLE, dco_pkg::RST_DEPTH,
                          dco_pkg::RST_RATE, dco_pkg::RST_FINE, dco_pkg::RST_COARSE};
         state_q     <= dco_pkg::DCO_OFF;
         phase_q     <= '0;
         step_q      <= 16'h4000;
         divCnt_q    <= 9'h0;
         startCnt_q  <= 10'h0;
         nvCnt_q     <= 24'h0;
         triCnt_q    <= 14'h0;
         gateOn_q    <= 1'b0;
         prdata_q    <= 32'h0;
         settleCnt_q <= 10'h0;
         sclPrev_q   <= 1'b1;
         sdaBit_q    <= 1'b1;
      end else begin
         cfg_q       <= cfg_d;
         state_q     <= state_d;
         phase_q     <= phase_d;
         step_q      <= step_d;
         divCnt_q    <= divCnt_d;
         startCnt_q  <= startCnt_d;
         nvCnt_q     <= nvCnt_d;
         triCnt_q    <= triCnt_d;
         gateOn_q    <= gateOn_d;
         prdata_q    <= prdata_d;
         settleCnt_q <= settleCnt_d;
         sclPrev_q   <= sclIn;
         if (sclIn && !sclPrev_q)
            sdaBit_q <= sdaIn;
      end
   end

   // serial pin is never driven high; only released until a bus engine is attached
   assign sdaOut = 1'b0;
   assign sdaOe  = 1'b0;
   assign settled = (state_q == dco_pkg::DCO_RUN) && (step_q == targetStep);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clkOut   <= 1'b0;
         clkOutOe <= 1'b0;
      end else begin
         clkOut   <= gateOn_q ? tap : 1'b0;
         clkOutOe <= gateOn_q || cfg_q.idleLow;
      end
   end
endmodule : dco_top

//--- tb/dco_top_monitor.sv
// port checker for the dithered clock output controller
`timescale 1ns/1ps
module dco_top_monitor #(
   parameter int STARTUP_COUNT = dco_pkg::STARTUP_CYCLES
) (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sdaOut,
   input wire logic        sdaOe,
   input wire logic        clkOut,
   input wire logic        clkOutOe,
   input wire logic        settled
);
   logic [15:0] upCnt_q;
   logic [15:0] upCnt_d;
   // saturates so a long run never wraps back under the startup figure
   always_comb begin
      upCnt_d = upCnt_q;
      if (upCnt_q != 16'hffff) upCnt_d = upCnt_q + 16'h1;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) upCnt_q <= 16'h0;
      else upCnt_q <= upCnt_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence apbAccess;
      psel && penable;
   endsequence
   sequence apbRead;
      psel && penable && !pwrite;
   endsequence
   AST_READY: assert property (apbAccess |-> pready) else $error("access not answered");
   AST_ERR_PHASE: assert property (pslverr |-> psel && penable) else $error("error outside access");
   AST_PRDATA_HOLD: assert property ($past(rst_n) && !$past(psel && !penable && !pwrite)
      |-> $stable(prdata)) else $error("read data moved without a read");
   AST_SDA_OPEN: assert property (sdaOe |-> !sdaOut) else $error("data line driven high");
   AST_IDLE_DRIVE: assert property (clkOut |-> clkOutOe) else $error("clock high undriven");
   AST_STARTUP: assert property (clkOut |-> upCnt_q >= STARTUP_COUNT - 1)
      else $error("output before startup count");
   AST_SETTLE: assert property (settled |-> upCnt_q >= STARTUP_COUNT - 1)
      else $error("settled before startup");
   AST_NO_RUNT: assert property ($past(rst_n) && $fell(clkOutOe) |-> !$past(clkOut))
      else $error("output cut while high");
   cover property (apbRead ##1 !psel);
endmodule : dco_top_monitor

bind dco_top dco_top_monitor #(.STARTUP_COUNT(STARTUP_COUNT)) u_dco_top_monitor (
   .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .clkOut(clkOut), .clkOutOe(clkOutOe), .settled(settled));

//--- tb/dco_load_model.sv
// downstream clock load plus the idle two-wire bus lines
`timescale 1ns/1ps
module dco_load_model (
   input wire logic mclk,
   input wire logic clkOut,
   input wire logic clkOutOe,
   input wire logic sdaOut,
   input wire logic sdaOe,
   output logic     sclIn,
   output logic     sdaIn,
   output int       riseCount
);
   logic lastClk;
   // no host traffic here: pull-ups hold both lines high between frames
   assign sclIn = 1'b1;
   assign sdaIn = (sdaOe && !sdaOut) ? 1'b0 : 1'b1;
   initial begin
      riseCount = 0;
      lastClk = 1'b0;
   end
   // a released pin counts nothing, whatever level the model last saw
   always @(posedge mclk) begin
      if (clkOutOe && clkOut && !lastClk) riseCount <= riseCount + 1;
      lastClk <= clkOut;
   end
endmodule : dco_load_model

//--- tb/dco_top_test.sv
// self-checking bench for the dithered clock output controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module dco_top_test;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} dco_row_type;
   logic        mclk, rst_n, psel, penable, pwrite, ditherEnable, outputGate, powerUp, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, sdaOut, sdaOe, clkOut, clkOutOe, settled, sclIn, sdaIn;
   int          riseCount, mismatches, cmp_count, e7, e8, e15, n;
   dco_row_type rows [8] = '{'{8'h00, 32'h13, 32'h13, 1'b0}, '{8'h04, 32'h00, 32'h00, 1'b0},
      '{8'h04, 32'h11, 32'h11, 1'b0}, '{8'h04, 32'h22, 32'h22, 1'b0},
      '{8'h04, 32'h04, 32'h04, 1'b0}, '{8'h04, 32'h17, 32'h17, 1'b0},
      '{8'h08, 32'h001203e8, 32'h001203e8, 1'b0}, '{8'h20, 32'h5, 32'h0, 1'b1}};
   dco_top #(.NV_CYCLES(20), .PHASE_BITS(16), .STARTUP_COUNT(8)) u_dco_top (.mclk(mclk),
      .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ditherEnable(ditherEnable),
      .outputGate(outputGate), .powerUp(powerUp), .sclIn(sclIn), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .clkOut(clkOut), .clkOutOe(clkOutOe), .settled(settled));
   dco_load_model u_dco_load_model (.mclk(mclk), .clkOut(clkOut), .clkOutOe(clkOutOe),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn), .riseCount(riseCount));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      er = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never re-drives psel in this time step
      @(posedge mclk);
   endtask : apb
   task automatic waitRun;
      do apb(1'b0, dco_pkg::ADDR_STATUS, 32'h0); while (rd[1:0] !== dco_pkg::DCO_RUN);
   endtask : waitRun
   task automatic measure(input logic [31:0] div, output int cnt);
      apb(1'b1, dco_pkg::ADDR_DIVIDE, div);
      repeat (600) @(posedge mclk);
      cnt = riseCount;
      repeat (8192) @(posedge mclk);
      cnt = riseCount - cnt;
   endtask : measure
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      #(90000 * 40);
      mismatches++;
      finish_test();
   end
   initial begin
      {mismatches, cmp_count} = '0;
      {rst_n, psel, penable, pwrite, paddr, pwdata, ditherEnable} = '0;
      {outputGate, powerUp} = 2'b11;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         `CHK("read back", rows[i].r, rd)
         `CHK("slave error", rows[i].e, er)
      end
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1 `CHK("clock after reset", 1'b0, clkOut)
      apb(1'b0, dco_pkg::ADDR_DIVIDE, 32'h0);
      `CHK("divide reset", {27'h0, dco_pkg::RST_IDLE, dco_pkg::RST_EXP}, rd)
      apb(1'b0, dco_pkg::ADDR_DITHER, 32'h0);
      `CHK("dither reset", {26'h0, dco_pkg::RST_RATE, 1'b0, dco_pkg::RST_DEPTH}, rd)
      apb(1'b0, dco_pkg::ADDR_TUNE, 32'h0);
      `CHK("tune reset", {11'h0, dco_pkg::RST_COARSE, 6'h0, dco_pkg::RST_FINE}, rd)
      waitRun();
      while (settled !== 1'b1) @(posedge mclk);
      apb(1'b0, dco_pkg::ADDR_STATUS, 32'h0);
      `CHK("gate on", 1'b1, rd[2])
      measure(32'h18, e8);
      measure(32'h1f, e15);
      measure(32'h17, e7);
      `CHK("top exponent", 1'b1, e15 >= e8 - 1 && e15 <= e8 + 1)
      `CHK("halving", 1'b1, e8 > 0 && e7 >= 2 * e8 - 2 && e7 <= 2 * e8 + 2)
      ditherEnable <= 1'b1;
      measure(32'h18, n);
      `CHK("dither lowers only", 1'b1, n <= e8 + 1)
      apb(1'b1, dco_pkg::ADDR_DIVIDE, 32'h11);
      outputGate <= 1'b0;
      repeat (300) @(posedge mclk);
      apb(1'b0, dco_pkg::ADDR_STATUS, 32'h0);
      `CHK("gated status", 3'b010, rd[2:0])
      `CHK("gated level", 2'b01, {clkOut, clkOutOe})
      apb(1'b1, dco_pkg::ADDR_DIVIDE, 32'h01);
      #1 `CHK("gated float", 1'b0, clkOutOe)
      outputGate <= 1'b1;
      powerUp <= 1'b0;
      repeat (dco_pkg::PDN_DEGLITCH_CYC + 600) @(posedge mclk);
      apb(1'b0, dco_pkg::ADDR_STATUS, 32'h0);
      `CHK("powered down", {dco_pkg::DCO_OFF, 2'b00}, {rd[1:0], clkOut, clkOutOe})
      powerUp <= 1'b1;
      waitRun();
      n = riseCount;
      repeat (300) @(posedge mclk);
      `CHK("restart", 1'b1, riseCount > n)
      apb(1'b1, dco_pkg::ADDR_NVWRITE, 32'h1);
      apb(1'b0, dco_pkg::ADDR_STATUS, 32'h0);
      `CHK("nv busy", 1'b1, rd[4])
      repeat (25) @(posedge mclk);
      apb(1'b0, dco_pkg::ADDR_STATUS, 32'h0);
      `CHK("nv done", 1'b0, rd[4])
      finish_test();
   end
endmodule : dco_top_test
